// ==== verilog/t2o_defines.svh ====
// Register offsets, field positions, reset values for the timer output block
`ifndef T2O_DEFINES_SVH
`define T2O_DEFINES_SVH

`define T2O_AW             8
`define T2O_DW             8
`define T2O_NPIN           7

`define T2O_ADDR_CTLA      8'h00
`define T2O_ADDR_CNT_HI    8'h01
`define T2O_ADDR_RLD_HI    8'h02
`define T2O_ADDR_CC_HI     8'h03
`define T2O_ADDR_LATCH     8'h04
`define T2O_ADDR_CTLB      8'h05
`define T2O_ADDR_STAT      8'h06
`define T2O_ADDR_MASK      8'h07

`define T2O_RST_CTLA       8'h00
`define T2O_RST_CTLB       8'h00
`define T2O_RST_CNT_HI     8'h00
`define T2O_RST_RLD_HI     8'h00
`define T2O_RST_CC_HI      8'h00
`define T2O_RST_LATCH      8'h1f
`define T2O_RST_STAT       2'h0
`define T2O_RST_MASK       2'h0

`define T2O_CTLA_POL       5
`define T2O_CTLA_OE0       6
`define T2O_CTLA_IRQEN     7
`define T2O_CTLB_OE1       0
`define T2O_CTLB_MODE      1
`define T2O_STAT_OVF       0
`define T2O_STAT_CC        1

`define T2O_PRI_BIT        0
`define T2O_CMP_BIT        1

`endif

// ==== verilog/t2o_pkg.sv ====
// Types shared by the timer output block
package t2o_pkg;

  typedef struct packed {
    logic       pwm16;
    logic       pwm_hi;
    logic       pwm_lo;
  } t2o_wave_t;

  typedef struct packed {
    logic       capcomp;
    logic       overflow;
  } t2o_evt_t;

  typedef struct packed {
    logic       vld;
    logic [7:0] val;
  } t2o_cnt_upd_t;

  typedef struct packed {
    logic [7:0] count_hi;
    logic [7:0] reload_hi;
    logic [7:0] capcomp_hi;
    logic       dual_byte_mode;
  } t2o_cfg_t;

endpackage

// ==== verilog/t2o_top.sv ====
// Timer 2 output steering, high byte registers, port latch and interrupt
`timescale 1ns/1ns
`default_nettype none
`include "t2o_defines.svh"

// What this block does
// - Enable fields pick latch or PWM on pins 0 and 1; pins 2-6 always carry latch
// - Dual mode: primary pin carries high-byte PWM
// - Dual mode: complement pin carries low-byte PWM
// - Local enable gates overflow and capcomp requests
// - Count high byte: reset zero, load, read
// - Reload high byte: read/write, reset zero
// - Capcomp high byte: read/write, reset zero
// - Port latch resets to 1f
// - Latch bit drives output or pull-up
// - Reads return latch; direction leaves it
// - Latch top bit reads zero
// - Polarity takes effect on enable rising
// - Dual mode splits timer into bytes
module t2o_top (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic [`T2O_AW-1:0]       addr,
  input  wire logic [`T2O_DW-1:0]       wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output var  logic [`T2O_DW-1:0]       rdata,
  input  wire t2o_pkg::t2o_wave_t       wave,
  input  wire t2o_pkg::t2o_evt_t        evt,
  input  wire t2o_pkg::t2o_cnt_upd_t    cnt_upd,
  input  wire logic [`T2O_NPIN-1:0]     pin_dir_out,
  output var  logic [`T2O_NPIN-1:0]     port_pin_out,
  output var  logic [`T2O_NPIN-1:0]     port_pin_oe,
  output var  logic [`T2O_NPIN-1:0]     port_pullup_en,
  output var  t2o_pkg::t2o_cfg_t        cfg,
  output var  logic                     irq
);

  // Registers
  logic [7:0]            ctla_r;
  logic [7:0]            ctlb_r;
  logic [7:0]            cnt_hi_r;
  logic [7:0]            rld_hi_r;
  logic [7:0]            cc_hi_r;
  logic [6:0]            latch_r;
  logic [1:0]            stat_r;
  logic [1:0]            mask_r;
  logic                  oe0_prev_r;
  logic                  pol_eff_r;

  // Address decode
  wire sel_ctla  = (addr == `T2O_ADDR_CTLA);
  wire sel_cnt   = (addr == `T2O_ADDR_CNT_HI);
  wire sel_rld   = (addr == `T2O_ADDR_RLD_HI);
  wire sel_cc    = (addr == `T2O_ADDR_CC_HI);
  wire sel_latch = (addr == `T2O_ADDR_LATCH);
  wire sel_ctlb  = (addr == `T2O_ADDR_CTLB);
  wire sel_stat  = (addr == `T2O_ADDR_STAT);
  wire sel_mask  = (addr == `T2O_ADDR_MASK);

  wire wr_ctla   = wr & sel_ctla;
  wire wr_cnt    = wr & sel_cnt;
  wire wr_rld    = wr & sel_rld;
  wire wr_cc     = wr & sel_cc;
  wire wr_latch  = wr & sel_latch;
  wire wr_ctlb   = wr & sel_ctlb;
  wire wr_stat   = wr & sel_stat;
  wire wr_mask   = wr & sel_mask;

  // Control fields
  wire irq_en    = ctla_r[`T2O_CTLA_IRQEN];
  wire oe0       = ctla_r[`T2O_CTLA_OE0];
  wire pol_sel   = ctla_r[`T2O_CTLA_POL];
  wire oe1       = ctlb_r[`T2O_CTLB_OE1];
  wire dual_mode = ctlb_r[`T2O_CTLB_MODE];

  // Polarity only reaches the pin on a fresh enable, so a stray write
  // while the waveform runs cannot glitch the primary output
  wire oe0_rise    = oe0 & ~oe0_prev_r;
  wire pol_eff_nxt = oe0_rise ? pol_sel : pol_eff_r;

  // Software load beats a counter update in the same cycle
  wire [7:0] cnt_hi_nxt = wr_cnt      ? wdata :
                          cnt_upd.vld ? cnt_upd.val : cnt_hi_r;
  wire [7:0] rld_hi_nxt = wr_rld ? wdata : rld_hi_r;
  wire [7:0] cc_hi_nxt  = wr_cc  ? wdata : cc_hi_r;
  wire [6:0] latch_nxt  = wr_latch ? wdata[6:0] : latch_r;
  // Control B keeps only its two defined bits
  wire [7:0] ctlb_nxt   = wr_ctlb ? {6'h00, wdata[1:0]} : ctlb_r;

  // Sticky status: the hardware set wins over a write-one clear
  wire [1:0] evt_vec  = {evt.capcomp, evt.overflow};
  wire [1:0] stat_clr = wr_stat ? wdata[1:0] : 2'h0;
  wire [1:0] stat_nxt = (stat_r & ~stat_clr) | evt_vec;
  wire       irq_nxt  = irq_en & |(stat_nxt & mask_r);

  // Pin source selection
  wire pri_wave = dual_mode ? wave.pwm_hi : wave.pwm16;
  wire cmp_wave = dual_mode ? wave.pwm_lo : wave.pwm16;
  wire pri_nxt  = oe0 ? (pri_wave ^ pol_eff_nxt)
                      : latch_r[`T2O_PRI_BIT];
  wire cmp_nxt  = oe1 ? cmp_wave : latch_r[`T2O_CMP_BIT];

  logic [`T2O_NPIN-1:0] pin_out_nxt;
  logic [`T2O_NPIN-1:0] pin_oe_nxt;
  logic [`T2O_NPIN-1:0] pullup_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < `T2O_NPIN; gi++)
    begin : g_pin
      wire wave_on = (gi == `T2O_PRI_BIT) ? oe0 :
                     (gi == `T2O_CMP_BIT) ? oe1 : 1'b0;
      wire wave_v  = (gi == `T2O_PRI_BIT) ? pri_nxt :
                     (gi == `T2O_CMP_BIT) ? cmp_nxt : latch_r[gi];
      assign pin_out_nxt[gi] = wave_on ? wave_v : latch_r[gi];
      assign pin_oe_nxt[gi]  = wave_on | pin_dir_out[gi];
      assign pullup_nxt[gi]  = ~pin_oe_nxt[gi] & latch_r[gi];
    end
  endgenerate

  // Read mux, unmapped addresses read zero
  wire [7:0] rd_mux =
    sel_ctla  ? ctla_r :
    sel_cnt   ? cnt_hi_r :
    sel_rld   ? rld_hi_r :
    sel_cc    ? cc_hi_r :
    sel_latch ? {1'b0, latch_r} :
    sel_ctlb  ? {6'h00, ctlb_r[1:0]} :
    sel_stat  ? {6'h00, stat_r} :
    sel_mask  ? {6'h00, mask_r} : 8'h00;
  wire [7:0] rdata_nxt = rd ? rd_mux : 8'h00;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctla_r   <= `T2O_RST_CTLA;
      ctlb_r   <= `T2O_RST_CTLB;
      cnt_hi_r <= `T2O_RST_CNT_HI;
      rld_hi_r <= `T2O_RST_RLD_HI;
      cc_hi_r  <= `T2O_RST_CC_HI;
      latch_r  <= 7'(`T2O_RST_LATCH);
      stat_r   <= `T2O_RST_STAT;
      mask_r   <= `T2O_RST_MASK;
    end
    else
    begin
      ctla_r   <= wr_ctla ? wdata : ctla_r;
      ctlb_r   <= ctlb_nxt;
      cnt_hi_r <= cnt_hi_nxt;
      rld_hi_r <= rld_hi_nxt;
      cc_hi_r  <= cc_hi_nxt;
      latch_r  <= latch_nxt;
      stat_r   <= stat_nxt;
      mask_r   <= wr_mask ? wdata[1:0] : mask_r;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      oe0_prev_r <= 1'b0;
      pol_eff_r  <= 1'b0;
    end
    else
    begin
      oe0_prev_r <= oe0;
      pol_eff_r  <= pol_eff_nxt;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata          <= 8'h00;
      port_pin_out   <= 7'(`T2O_RST_LATCH);
      port_pin_oe    <= 7'h00;
      port_pullup_en <= 7'h00;
      irq            <= 1'b0;
      cfg            <= '0;
    end
    else
    begin
      rdata          <= rdata_nxt;
      port_pin_out   <= pin_out_nxt;
      port_pin_oe    <= pin_oe_nxt;
      port_pullup_en <= pullup_nxt;
      irq            <= irq_nxt;
      // Next values, so the core copy never lags the registers
      cfg            <= {cnt_hi_nxt, rld_hi_nxt, cc_hi_nxt,
                         ctlb_nxt[`T2O_CTLB_MODE]};
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_oe0_rise;
    oe0 && !oe0_prev_r;
  endsequence

  sequence s_ovf_armed;
    evt.overflow && irq_en && mask_r[`T2O_STAT_OVF];
  endsequence

  sequence s_pri_steady16;
    oe0 && oe0_prev_r && !dual_mode;
  endsequence

  a_pri_pwm16: assert property (
    s_pri_steady16 |=> port_pin_out[`T2O_PRI_BIT] ==
      ($past(wave.pwm16) ^ $past(pol_eff_r)))
    else $error("primary pin not carrying 16-bit wave");

  a_pri_latch: assert property (
    !oe0 |=> port_pin_out[`T2O_PRI_BIT] == $past(latch_r[`T2O_PRI_BIT]))
    else $error("primary pin not carrying latch data");

  a_pri_dual_hi: assert property (
    (oe0 && oe0_prev_r && dual_mode) |=>
      port_pin_out[`T2O_PRI_BIT] ==
      ($past(wave.pwm_hi) ^ $past(pol_eff_r)))
    else $error("primary pin not carrying high byte wave");

  a_cmp_dual_lo: assert property (
    (oe1 && dual_mode) |=>
      port_pin_out[`T2O_CMP_BIT] == $past(wave.pwm_lo) &&
      port_pin_oe[`T2O_CMP_BIT])
    else $error("complement pin not carrying low byte wave");

  a_cmp_latch: assert property (
    !oe1 |=> port_pin_out[`T2O_CMP_BIT] == $past(latch_r[`T2O_CMP_BIT]))
    else $error("complement pin not carrying latch data");

  a_irq_gated: assert property (
    !irq_en |=> !irq)
    else $error("interrupt raised with local enable clear");

  a_irq_raise: assert property (
    s_ovf_armed |=> irq ##0 stat_r[`T2O_STAT_OVF])
    else $error("enabled overflow did not raise interrupt");

  a_sticky_set: assert property (
    evt.capcomp |=> stat_r[`T2O_STAT_CC])
    else $error("capcomp flag lost against clear");

  a_cnt_read: assert property (
    (rd && sel_cnt) |=> rdata == $past(cnt_hi_r))
    else $error("count high read mismatch");

  a_rld_write: assert property (
    wr_rld |=> rld_hi_r == $past(wdata) ##1 (rld_hi_r == $past(rld_hi_r)
      || $past(wr_rld)))
    else $error("reload high byte did not hold write");

  a_cc_hold: assert property (
    !wr_cc |=> $stable(cc_hi_r))
    else $error("capcomp high byte changed without write");

  a_latch_read: assert property (
    (rd && sel_latch) |=> rdata == {1'b0, $past(latch_r)})
    else $error("latch read mismatch or top bit set");

  a_latch_dir: assert property (
    (!wr_latch && $changed(pin_dir_out)) |=> $stable(latch_r))
    else $error("direction change altered latch");

  a_pullup: assert property (
    !pin_dir_out[2] |=> port_pullup_en[2] == $past(latch_r[2]))
    else $error("pull-up not following latch bit");

  a_pol_take: assert property (
    s_oe0_rise |=> pol_eff_r == $past(pol_sel))
    else $error("polarity not taken on enable rise");

  a_pol_hold: assert property (
    !(oe0 && !oe0_prev_r) |=> $stable(pol_eff_r))
    else $error("polarity changed without enable rise");

  a_mode_out: assert property (
    wr_ctlb |=> cfg.dual_byte_mode == $past(wdata[`T2O_CTLB_MODE]))
    else $error("dual mode not reported");

  a_cmp_pwm16: assert property (
    (oe1 && !dual_mode) |=>
      port_pin_out[`T2O_CMP_BIT] == $past(wave.pwm16))
    else $error("complement pin not carrying 16-bit wave");

  a_pri_drive: assert property (
    oe0 |=> port_pin_oe[`T2O_PRI_BIT])
    else $error("primary pin not driven while enabled");

  a_ovf_sticky: assert property (
    evt.overflow |=> stat_r[`T2O_STAT_OVF])
    else $error("overflow flag lost against clear");

  a_irq_source: assert property (
    irq |-> |(stat_r & $past(mask_r)))
    else $error("interrupt without a masked-in status bit");

  a_latch_write: assert property (
    wr_latch |=> latch_r == $past(wdata[6:0]))
    else $error("latch write not stored");

endmodule
`default_nettype wire

// ==== tb/t2o_pin_model.sv ====
// Pin-side model: resolves each port line from drive and weak pull-up
`timescale 1ns/1ns
`default_nettype none
module t2o_pin_model (
  input  wire logic       clk,
  input  wire logic [6:0] pin_out,
  input  wire logic [6:0] pin_oe,
  input  wire logic [6:0] pullup_en,
  output var  logic [6:0] pin_lvl
);
  logic [6:0] float_r = 7'h00;

  // A floating line wanders, so a stale value never passes for a drive
  always_ff @(posedge clk)
    float_r <= ~float_r;

  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & pullup_en)
                 | (~pin_oe & ~pullup_en & float_r);
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the timer output block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                  clk;
  logic                  nrst;
  logic                  wr;
  logic                  rd;
  logic                  irq;
  logic [7:0]            addr;
  logic [7:0]            wdata;
  logic [7:0]            rdata;
  logic [6:0]            dir;
  logic [6:0]            p_out;
  logic [6:0]            p_oe;
  logic [6:0]            p_pu;
  logic [6:0]            lvl;
  t2o_pkg::t2o_wave_t    wave;
  t2o_pkg::t2o_evt_t     evt;
  t2o_pkg::t2o_cnt_upd_t cnt_upd;
  t2o_pkg::t2o_cfg_t     cfg;
  int                    errors;
  int                    samples_checked;

  t2o_top t2o_top_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .wave(wave), .evt(evt),
    .cnt_upd(cnt_upd), .pin_dir_out(dir), .port_pin_out(p_out),
    .port_pin_oe(p_oe), .port_pullup_en(p_pu), .cfg(cfg), .irq(irq));

  t2o_pin_model t2o_pin_model_i (.clk(clk), .pin_out(p_out), .pin_oe(p_oe),
    .pullup_en(p_pu), .pin_lvl(lvl));

  task automatic wrap_up;
    $display("checked %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic t_regs;
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'h1f);
    wr_reg(8'h02, 8'ha5);
    wr_reg(8'h03, 8'h5a);
    wr_reg(8'h04, 8'hff);
    rd_chk(8'h02, 8'ha5);
    rd_chk(8'h03, 8'h5a);
    rd_chk(8'h04, 8'h7f);
    rd_chk(8'h09, 8'h00);
    chk(cfg.reload_hi, 8'ha5);
    @(posedge clk);
    cnt_upd <= {1'b1, 8'h3c};
    @(posedge clk);
    cnt_upd <= '0;
    rd_chk(8'h01, 8'h3c);
    wr_reg(8'h01, 8'hc3);
    rd_chk(8'h01, 8'hc3);
    chk(cfg.count_hi, 8'hc3);
    chk(cfg.capcomp_hi, 8'h5a);
    $display("test regs done");
  endtask

  task automatic t_steer;
    wr_reg(8'h04, 8'h00);
    for (int m = 0; m < 2; m++)
      for (int f = 0; f < 4; f++)
      begin
        @(posedge clk);
        wave <= (m == 1) ? 3'b011 : 3'b100;
        wr_reg(8'h00, {1'b0, f[0], 6'h00});
        wr_reg(8'h05, {6'h00, m[0], f[1]});
        cyc(2);
        chk({6'h00, p_out[1:0]}, {6'h00, f[1:0]});
        chk({6'h00, p_oe[1:0]}, {6'h00, f[1:0]});
        chk({7'h00, cfg.dual_byte_mode}, {7'h00, m[0]});
      end
    wr_reg(8'h00, 8'h00);
    wr_reg(8'h05, 8'h00);
    wave <= 3'b000;
    wr_reg(8'h00, 8'h20);
    cyc(2);
    chk({7'h00, p_out[0]}, 8'h00);
    wr_reg(8'h00, 8'h60);
    cyc(2);
    chk({7'h00, p_out[0]}, 8'h01);
    wr_reg(8'h00, 8'h40);
    cyc(2);
    chk({7'h00, lvl[0]}, 8'h01);
    $display("test steer done");
  endtask

  task automatic t_irq;
    wr_reg(8'h00, 8'h80);
    wr_reg(8'h07, 8'h01);
    @(posedge clk);
    evt <= 2'b01;
    @(posedge clk);
    evt <= 2'b00;
    #1 chk({7'h00, irq}, 8'h01);
    rd_chk(8'h06, 8'h01);
    wr_reg(8'h00, 8'h00);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    wr_reg(8'h00, 8'h80);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    wr_reg(8'h06, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    evt <= 2'b10;
    @(posedge clk);
    evt <= 2'b00;
    cyc(1);
    chk({7'h00, irq}, 8'h00);
    rd_chk(8'h06, 8'h02);
    wr_reg(8'h07, 8'h03);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    // Clear both flags in the cycle a new overflow arrives
    @(posedge clk);
    wr <= 1'b1;
    addr <= 8'h06;
    wdata <= 8'h03;
    evt <= 2'b01;
    @(posedge clk);
    wr <= 1'b0;
    evt <= 2'b00;
    rd_chk(8'h06, 8'h01);
    $display("test irq done");
  endtask

  task automatic t_pins;
    wr_reg(8'h00, 8'h00);
    wr_reg(8'h05, 8'h00);
    wr_reg(8'h04, 8'h55);
    cyc(2);
    chk({1'b0, p_pu}, 8'h55);
    @(posedge clk);
    dir <= 7'h7f;
    cyc(2);
    chk({1'b0, lvl}, 8'h55);
    chk({1'b0, p_pu}, 8'h00);
    rd_chk(8'h04, 8'h55);
    $display("test pins done");
  endtask

  task automatic t_rst;
    wr_reg(8'h02, 8'h33);
    wr_reg(8'h03, 8'h44);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h02, 8'h00);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'h1f);
    chk(cfg.reload_hi, 8'h00);
    $display("test reset done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("MISMATCH t=%0t run timed out", $time);
    wrap_up();
  end

  initial
  begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    dir = 7'h00;
    wave = '0;
    evt = '0;
    cnt_upd = '0;
    errors = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_steer();
    t_irq();
    t_pins();
    t_rst();
    wrap_up();
  end
endmodule
`default_nettype wire
